// ---- rtl/handler_pkg.sv ----
// handler_pkg: constants, field layout and state codes of the handler block
// assumes a single 25 MHz system clock; all counts derive from that rate
package handler_pkg;

  // clock rate, in the two units used below
  localparam int CLK_KHZ = 25000; // 25 MHz in kHz
  localparam int CLK_MHZ = 25; // 25 MHz in MHz

  // times as printed
  localparam int T_CHG_DLY_MS = 100; // charge to measure delay, typical
  localparam int T_DIS_HOLD_MS = 100; // result hold in discharge, typical
  localparam int T_AD_FAST_US = 12200; // conversion time fast, longest
  localparam int T_AD_MED_US = 62600; // conversion time medium, longest
  localparam int T_AD_SLOW_US = 256000; // conversion time slow, longest
  localparam int T_CYC_FAST_MS = 17; // whole cycle fast, longest
  localparam int T_CYC_MED_MS = 67; // whole cycle medium, longest
  localparam int T_CYC_SLOW_MS = 260; // whole cycle slow, longest
  localparam int T_LEAD_US = 10; // results ahead of end of conversion
  localparam int T_NEXT_US = 10; // next start after end of conversion

  // the same times in clock cycles (all figures divide evenly)
  localparam int CHG_DLY_CYC = T_CHG_DLY_MS * CLK_KHZ;
  localparam int DIS_HOLD_CYC = T_DIS_HOLD_MS * CLK_KHZ;
  localparam int AD_FAST_CYC = T_AD_FAST_US * CLK_MHZ;
  localparam int AD_MED_CYC = T_AD_MED_US * CLK_MHZ;
  localparam int AD_SLOW_CYC = T_AD_SLOW_US * CLK_MHZ;
  localparam int CYC_FAST_CYC = T_CYC_FAST_MS * CLK_KHZ;
  localparam int CYC_MED_CYC = T_CYC_MED_MS * CLK_KHZ;
  localparam int CYC_SLOW_CYC = T_CYC_SLOW_MS * CLK_KHZ;
  localparam int LEAD_CYC = T_LEAD_US * CLK_MHZ;
  localparam int NEXT_CYC = T_NEXT_US * CLK_MHZ;

  // widths
  localparam int TMR_W = 24; // timer width, holds the slow cycle
  localparam int CNT_W = 16; // measurement counter width
  localparam int ADR_W = 4; // wishbone byte address width
  localparam int DAT_W = 32; // wishbone data width

  // register byte addresses
  localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0; // rate, trigger mode, commands
  localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4; // state and outputs
  localparam logic [ADR_W-1:0] ADR_COUNT = 4'h8; // finished measurements

  // control fields
  localparam int CTRL_RATE_LSB = 0; // two bits
  localparam int CTRL_TRIG_LSB = 2; // two bits
  localparam int CTRL_SWCHG_BIT = 4; // write 1: charge request
  localparam int CTRL_SWDIS_BIT = 5; // write 1: discharge request
  localparam int CTRL_SWTRIG_BIT = 6; // write 1: manual trigger

  // status fields
  localparam int STAT_STATE_LSB = 0; // three bits
  localparam int STAT_VOLT_BIT = 3; // test voltage on
  localparam int STAT_EOC_BIT = 4; // end of conversion active
  localparam int STAT_PASS_BIT = 5; // pass verdict active
  localparam int STAT_FAIL_BIT = 6; // fail verdict active
  localparam int STAT_CONT_BIT = 7; // contact fail active

  typedef enum logic [1:0] {
    RATE_FAST = 2'b00,
    RATE_MED = 2'b01,
    RATE_SLOW = 2'b10
  } rate_t;

  typedef enum logic [1:0] {
    TRIG_INT = 2'b00,
    TRIG_MAN = 2'b01,
    TRIG_EXT = 2'b10
  } trig_t;

  typedef enum logic [2:0] {
    ST_DISCHARGE = 3'b000,
    ST_CHARGE = 3'b001,
    ST_READY = 3'b010,
    ST_MEASURE = 3'b011,
    ST_JUDGE = 3'b100,
    ST_DONE = 3'b101
  } state_t;

  // values after reset
  localparam logic [1:0] RATE_RST = 2'h0; // fast
  localparam logic [1:0] TRIG_RST = 2'h2; // external

endpackage

// ---- rtl/handler_screening_interface.sv ----
// handler_screening_interface: charge/discharge, trigger and result timing
// for the handler port, with a wishbone classic register slave.
// assumes measPass and contactGood come from logic on mclk and are valid
// at the end of the conversion time; handler pins are asynchronous.
`timescale 1ns/100ps
module handler_screening_interface #(
  parameter int unsigned CHG_DLY_CYC = handler_pkg::CHG_DLY_CYC, // charge settle
  parameter int unsigned DIS_HOLD_CYC = handler_pkg::DIS_HOLD_CYC, // discharge hold
  parameter int unsigned AD_FAST_CYC = handler_pkg::AD_FAST_CYC, // conversion fast
  parameter int unsigned AD_MED_CYC = handler_pkg::AD_MED_CYC, // conversion medium
  parameter int unsigned AD_SLOW_CYC = handler_pkg::AD_SLOW_CYC // conversion slow
) (
  input wire logic mclk, // system clock, 25 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [handler_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [handler_pkg::DAT_W-1:0] wb_dat_i, // write data
  output logic [handler_pkg::DAT_W-1:0] wb_dat_o, // read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic discharge_cmd_n, // handler discharge pin, low
  input wire logic charge_test_cmd_n, // handler charge pin, low
  input wire logic ext_trigger_in, // trigger pin, high range
  input wire logic ext_trigger_in_low_voltage, // trigger pin, low range
  input wire logic measPass, // comparator verdict, high = pass
  input wire logic contactGood, // contact check, high = good
  output logic contact_fail_n, // contact fail, low
  output logic no_voltage_n, // no test voltage, low
  output logic screen_pass_n, // pass verdict, low
  output logic screen_fail_n, // fail verdict, low
  output logic conversion_done_n, // end of conversion, low
  output logic testVoltageEn, // test voltage source on
  output logic prechargeEn // precharge source on
);
  import handler_pkg::*;

  // refuse counts the timer cannot hold
  if (CHG_DLY_CYC < 1 || CHG_DLY_CYC >= 2 ** TMR_W || DIS_HOLD_CYC < 1 ||
      DIS_HOLD_CYC >= 2 ** TMR_W || AD_FAST_CYC < 1 || AD_FAST_CYC >= 2 ** TMR_W ||
      AD_MED_CYC < 1 || AD_MED_CYC >= 2 ** TMR_W || AD_SLOW_CYC < 1 ||
      AD_SLOW_CYC >= 2 ** TMR_W) begin
    $error("handler timing count out of timer range");
  end

  // pin filters
  pin_sync_if dischargeIf(); // discharge pin
  pin_sync_if chgIf(); // charge pin
  pin_sync_if trigIf(); // either trigger pin

  assign dischargeIf.raw = discharge_cmd_n;
  assign chgIf.raw = charge_test_cmd_n;
  // both trigger inputs feed one coupler path, so merge before the filter
  assign trigIf.raw = ext_trigger_in | ext_trigger_in_low_voltage;

  pin_sync #(.IDLE(1'b1)) dischargeSync (.mclk(mclk), .sys_rst(sys_rst), .sig(dischargeIf));
  pin_sync #(.IDLE(1'b1)) chgSync (.mclk(mclk), .sys_rst(sys_rst), .sig(chgIf));
  pin_sync #(.IDLE(1'b0)) trigSync (.mclk(mclk), .sys_rst(sys_rst), .sig(trigIf));

  // ---------------- register slave ----------------
  logic ackQ_q, ackQ_d; // acknowledge
  logic [DAT_W-1:0] rdat_q, rdat_d; // registered read data
  logic [1:0] rate_q, rate_d; // measurement rate
  logic [1:0] trig_q, trig_d; // trigger mode
  logic busReq; // live request
  logic ctrlWr; // control write taking effect
  logic swChg, swDis, swTrig; // command pulses from software

  // state of the measurement sequencer, declared here for status reads
  state_t state_q, state_d; // sequencer state
  logic [TMR_W-1:0] tmr_q, tmr_d; // down counter
  logic passN_q, passN_d; // pass output
  logic failN_q, failN_d; // fail output
  logic contN_q, contN_d; // contact fail output
  logic eocN_q, eocN_d; // end of conversion output
  logic voltOn_q, voltOn_d; // sources on
  logic [CNT_W-1:0] measCnt_q, measCnt_d; // finished measurements

  // ack one cycle after the request, dropped the cycle after
  always_comb begin
    busReq = wb_cyc_i & wb_stb_i;
    ackQ_d = busReq & ~ackQ_q;
    // writes act on the edge where the master sees ack
    ctrlWr = busReq & ackQ_q & wb_we_i & wb_sel_i[0] & (wb_adr_i[3:2] == ADR_CTRL[3:2]);
    rate_d = ctrlWr ? wb_dat_i[CTRL_RATE_LSB +: 2] : rate_q;
    trig_d = ctrlWr ? wb_dat_i[CTRL_TRIG_LSB +: 2] : trig_q;
    swChg = ctrlWr & wb_dat_i[CTRL_SWCHG_BIT];
    swDis = ctrlWr & wb_dat_i[CTRL_SWDIS_BIT];
    swTrig = ctrlWr & wb_dat_i[CTRL_SWTRIG_BIT];
    rdat_d = rdat_q;
    // read data captured as ack rises; unmapped words read zero
    if (busReq && !ackQ_q) begin
      rdat_d = '0;
      case (wb_adr_i[3:2])
        ADR_CTRL[3:2]: begin
          rdat_d[CTRL_RATE_LSB +: 2] = rate_q;
          rdat_d[CTRL_TRIG_LSB +: 2] = trig_q;
        end
        ADR_STATUS[3:2]: begin
          rdat_d[STAT_STATE_LSB +: 3] = state_q;
          rdat_d[STAT_VOLT_BIT] = voltOn_q;
          rdat_d[STAT_EOC_BIT] = ~eocN_q;
          rdat_d[STAT_PASS_BIT] = ~passN_q;
          rdat_d[STAT_FAIL_BIT] = ~failN_q;
          rdat_d[STAT_CONT_BIT] = ~contN_q;
        end
        ADR_COUNT[3:2]: begin
          rdat_d[CNT_W-1:0] = measCnt_q;
        end
        default: begin
          rdat_d = '0;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ackQ_q <= 1'b0;
      rdat_q <= '0;
      rate_q <= RATE_RST;
      trig_q <= TRIG_RST;
    end else begin
      ackQ_q <= ackQ_d;
      rdat_q <= rdat_d;
      rate_q <= rate_d;
      trig_q <= trig_d;
    end
  end

  assign wb_ack_o = ackQ_q;
  assign wb_dat_o = rdat_q;

  // ---------------- measurement sequencer ----------------
  logic dischargeReq, chgReq, trigFire, judgeLoad; // decoded requests
  logic [TMR_W-1:0] adLoad; // conversion time for the rate

  // request decode and rate lookup
  always_comb begin
    // pin held low long enough to clear the filter
    dischargeReq = ~dischargeIf.level | swDis;
    // charge pulse is gone before the next discharge ends
    chgReq = ~chgIf.level | swChg;
    case (trig_q)
      TRIG_INT: trigFire = 1'b1;
      TRIG_EXT: trigFire = trigIf.rise;
      default: trigFire = swTrig; // manual; code 3 behaves the same
    endcase
    case (rate_q)
      RATE_FAST: adLoad = TMR_W'(AD_FAST_CYC - 1);
      RATE_MED: adLoad = TMR_W'(AD_MED_CYC - 1);
      default: adLoad = TMR_W'(AD_SLOW_CYC - 1);
    endcase
    judgeLoad = (state_q == ST_MEASURE) && (tmr_q == '0) && !dischargeReq;
  end

  // timers load count-1 so each state lasts exactly the count
  always_comb begin
    state_d = state_q;
    tmr_d = (tmr_q != '0) ? tmr_q - TMR_W'(1) : tmr_q;
    passN_d = passN_q;
    failN_d = failN_q;
    contN_d = contN_q;
    eocN_d = eocN_q;
    voltOn_d = voltOn_q;
    measCnt_d = measCnt_q;
    if (dischargeReq && state_q != ST_DISCHARGE) begin
      // discharge wins from every test state; sources off at once
      state_d = ST_DISCHARGE;
      tmr_d = TMR_W'(DIS_HOLD_CYC - 1);
      voltOn_d = 1'b0;
    end else begin
      case (state_q)
        ST_DISCHARGE: begin
          if (chgReq && !dischargeReq) begin
            state_d = ST_CHARGE;
            tmr_d = TMR_W'(CHG_DLY_CYC - 1);
            voltOn_d = 1'b1;
          end else if (tmr_q == '0) begin
            // hold time over: results released to inactive
            passN_d = 1'b1;
            failN_d = 1'b1;
            contN_d = 1'b1;
            eocN_d = 1'b1;
          end
        end
        ST_CHARGE: begin
          if (tmr_q == '0) begin
            state_d = ST_READY;
          end
        end
        ST_READY: begin
          if (trigFire) begin
            state_d = ST_MEASURE;
            tmr_d = adLoad;
            eocN_d = 1'b1;
          end
        end
        ST_MEASURE: begin
          if (tmr_q == '0) begin
            // old results held until this point
            state_d = ST_JUDGE;
            tmr_d = TMR_W'(LEAD_CYC - 1);
            passN_d = ~(measPass & contactGood);
            failN_d = measPass & contactGood;
            contN_d = contactGood;
          end
        end
        ST_JUDGE: begin
          if (tmr_q == '0) begin
            state_d = ST_DONE;
            tmr_d = TMR_W'(NEXT_CYC - 1);
            eocN_d = 1'b0;
            measCnt_d = measCnt_q + CNT_W'(1);
          end
        end
        ST_DONE: begin
          // triggers during the restart gap are dropped
          if (tmr_q == '0) begin
            state_d = ST_READY;
          end
        end
        default: begin
          state_d = ST_DISCHARGE;
          voltOn_d = 1'b0;
        end
      endcase
    end
  end

  // sequencer registers; power up in discharge with sources off
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_DISCHARGE;
      tmr_q <= '0;
      passN_q <= 1'b1;
      failN_q <= 1'b1;
      contN_q <= 1'b1;
      eocN_q <= 1'b1;
      voltOn_q <= 1'b0;
      measCnt_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      passN_q <= passN_d;
      failN_q <= failN_d;
      contN_q <= contN_d;
      eocN_q <= eocN_d;
      voltOn_q <= voltOn_d;
      measCnt_q <= measCnt_d;
    end
  end

  // pin outputs, all straight from flip-flops
  assign screen_pass_n = passN_q;
  assign screen_fail_n = failN_q;
  assign contact_fail_n = contN_q;
  assign conversion_done_n = eocN_q;
  assign no_voltage_n = voltOn_q;
  assign testVoltageEn = voltOn_q;
  assign prechargeEn = voltOn_q;

  // ---------------- checks ----------------
  logic [TMR_W-1:0] chgCnt_q, chgCnt_d; // cycles spent charging
  logic [TMR_W-1:0] cycCnt_q, cycCnt_d; // cycles since measurement start
  logic [TMR_W-1:0] judgeCnt_q, judgeCnt_d; // cycles verdict shown before eoc
  logic [TMR_W-1:0] maxCyc; // whole-cycle bound for the rate

  // helper counters read only by the checks
  always_comb begin
    chgCnt_d = (state_q == ST_CHARGE) ? chgCnt_q + TMR_W'(1) : '0;
    cycCnt_d = (state_q == ST_MEASURE || state_q == ST_JUDGE) ? cycCnt_q + TMR_W'(1) : '0;
    judgeCnt_d = (state_q == ST_JUDGE) ? judgeCnt_q + TMR_W'(1) : '0;
    case (rate_q)
      RATE_FAST: maxCyc = TMR_W'(CYC_FAST_CYC);
      RATE_MED: maxCyc = TMR_W'(CYC_MED_CYC);
      default: maxCyc = TMR_W'(CYC_SLOW_CYC);
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chgCnt_q <= '0;
      cycCnt_q <= '0;
      judgeCnt_q <= '0;
    end else begin
      chgCnt_q <= chgCnt_d;
      cycCnt_q <= cycCnt_d;
      judgeCnt_q <= judgeCnt_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence extEdge;
    state_q == ST_READY && !dischargeReq && trig_q == TRIG_EXT && trigIf.rise;
  endsequence

  sequence convEnd;
    state_q == ST_JUDGE && tmr_q == '0 && !dischargeReq;
  endsequence

  sequence eocHeld;
    !conversion_done_n && state_q == ST_DONE ##1 !conversion_done_n;
  endsequence

  chgEnter_a: assert property (
    state_q == ST_DISCHARGE && chgReq && !dischargeReq |=> state_q == ST_CHARGE && testVoltageEn)
    else $error("charge request did not enter charging");
  chgDelay_a: assert property (
    state_q == ST_READY && $past(state_q) == ST_CHARGE |-> chgCnt_q == CHG_DLY_CYC)
    else $error("charge delay length wrong");
  trigEdge_a: assert property (
    extEdge |=> state_q == ST_MEASURE && conversion_done_n)
    else $error("trigger edge did not start measurement");
  trigMode_a: assert property (
    state_q == ST_READY && trig_q != TRIG_INT &&
    !(trig_q == TRIG_EXT ? trigIf.rise : swTrig) |=> state_q != ST_MEASURE)
    else $error("measurement started without a valid trigger");
  cycBound_a: assert property (
    $fell(conversion_done_n) |-> cycCnt_q <= maxCyc)
    else $error("measurement cycle too long");
  leadTime_a: assert property (
    $fell(conversion_done_n) |-> judgeCnt_q == LEAD_CYC && $stable(screen_pass_n))
    else $error("verdict lead before end of conversion wrong");
  eocFall_a: assert property (
    convEnd |=> eocHeld)
    else $error("end of conversion not driven low");
  noVolt_a: assert property (
    state_q == ST_DISCHARGE || state_q == ST_CHARGE && $past(state_q) == ST_DISCHARGE |->
    no_voltage_n == testVoltageEn && (no_voltage_n == (state_q != ST_DISCHARGE)))
    else $error("no voltage output disagrees with sources");
  oneVerdict_a: assert property (
    !conversion_done_n |-> screen_pass_n != screen_fail_n)
    else $error("pass and fail not exclusive");
  dischargeHold_a: assert property (
    state_q == ST_DISCHARGE && tmr_q != '0 |=> $stable(screen_pass_n) && $stable(screen_fail_n))
    else $error("results changed during discharge hold");
  testHold_a: assert property (
    state_q != ST_DISCHARGE && !judgeLoad && !dischargeReq |=> $stable(screen_pass_n) && $stable(contact_fail_n))
    else $error("results changed without a new verdict");
  dischargeOff_a: assert property (
    dischargeReq |=> state_q == ST_DISCHARGE && !testVoltageEn && !prechargeEn)
    else $error("discharge left a source on");

endmodule

// ---- rtl/pin_sync.sv ----
// pin_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to mclk; IDLE is the pin's resting level
`timescale 1ns/100ps
module pin_sync #(
  parameter bit IDLE = 1'b1 // level assumed during reset
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  pin_sync_if.filt sig // raw in, filtered out
);

  logic s1_q, s2_q, s3_q, lvl_q; // stages and accepted level
  logic s1_d, s2_d, s3_d, lvl_d; // next values

  // accept a change only once stages two and three agree
  always_comb begin
    s1_d = sig.raw;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
  end

  // stage registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
      lvl_q <= IDLE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  // rise fires in the cycle the new level is accepted
  assign sig.level = lvl_q;
  assign sig.rise = (s2_q == s3_q) && s2_q && !lvl_q;

endmodule

// ---- rtl/pin_sync_if.sv ----
// pin_sync_if: one handler input pin, raw and filtered
// assumes the filter and its user share mclk
`timescale 1ns/100ps
interface pin_sync_if;
  logic raw; // pin level as it arrives
  logic level; // filtered level
  logic rise; // one-cycle pulse on a filtered rising edge
  modport filt (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface

// ---- tb/handler_model.sv ----
// handler_model: automatic handler driving the screening port pins
// assumes it shares mclk with the device; command pins rest high by pull-up
`timescale 1ns/100ps
module handler_model #(
  parameter int CHG_HOLD = 12, // charge low time, scaled down
  parameter int DIS_HOLD = 10 // discharge low time, scaled down
) (
  input wire logic mclk, // system clock
  output logic dischargeN, // discharge command, low
  output logic chargeN, // charge command, low
  output logic trigHi, // trigger, high range pin
  output logic trigLo // trigger, low range pin
);
  // idle levels: pull-ups on commands, trigger low
  initial begin
    dischargeN = 1'b1;
    chargeN = 1'b1;
    trigHi = 1'b0;
    trigLo = 1'b0;
  end
  // discharge held low for the minimum hold time
  task automatic discharge_pulse();
    @(posedge mclk);
    dischargeN <= 1'b0;
    repeat (DIS_HOLD) @(posedge mclk);
    dischargeN <= 1'b1;
  endtask
  // charge held low inside the allowed window
  task automatic charge_pulse();
    @(posedge mclk);
    chargeN <= 1'b0;
    repeat (CHG_HOLD) @(posedge mclk);
    chargeN <= 1'b1;
  endtask
  // rising edge on one of the two trigger pins, then held high
  task automatic trig_rise(input bit lowPin);
    @(posedge mclk);
    if (lowPin) begin
      trigLo <= 1'b1;
    end else begin
      trigHi <= 1'b1;
    end
  endtask
  // both trigger pins back to rest
  task automatic trig_fall();
    @(posedge mclk);
    trigHi <= 1'b0;
    trigLo <= 1'b0;
  endtask
endmodule

// ---- tb/tb_handler_screening_interface.sv ----
// tb_handler_screening_interface: bus, handler pins and verdict inputs
// assumes shortened timing parameters; expectations use the same values
`timescale 1ns/100ps
module tb_handler_screening_interface;
  import handler_pkg::*;
  localparam int AD_C [3] = '{40, 60, 80}; // conversion cycles per rate
  localparam int CHG_C = 20; // charge settle cycles
  localparam int DIS_C = 30; // discharge hold cycles
  logic mclk = 1'b0; // system clock
  logic sysRst = 1'b1; // reset, high
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0; // bus controls
  logic [3:0] wbAdr = 4'h0; // byte address
  logic [31:0] wbDatW = 32'h0, wbDatR, rd; // write, read, taken data
  logic wbAck; // acknowledge
  logic mp = 1'b1, cg = 1'b1; // verdict inputs
  logic dischargeN, chargeN, trigHi, trigLo; // handler pins
  logic contactFailN, noVoltN, passN, failN, doneN, tvEn, pcEn; // device outputs
  int mismatches = 0, checksDone = 0, cnt, i; // counters
  // clock at 25 MHz
  always #20 mclk = ~mclk;
  handler_screening_interface #(.CHG_DLY_CYC(CHG_C), .DIS_HOLD_CYC(DIS_C), .AD_FAST_CYC(AD_C[0]),
    .AD_MED_CYC(AD_C[1]), .AD_SLOW_CYC(AD_C[2])) u_handler_screening_interface (.mclk(mclk),
    .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(4'hf), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .discharge_cmd_n(dischargeN), .charge_test_cmd_n(chargeN), .ext_trigger_in(trigHi),
    .ext_trigger_in_low_voltage(trigLo), .measPass(mp), .contactGood(cg),
    .contact_fail_n(contactFailN), .no_voltage_n(noVoltN), .screen_pass_n(passN),
    .screen_fail_n(failN), .conversion_done_n(doneN), .testVoltageEn(tvEn), .prechargeEn(pcEn));
  handler_model u_handler_model (.mclk(mclk), .dischargeN(dischargeN), .chargeN(chargeN),
    .trigHi(trigHi), .trigLo(trigLo));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected pass pin: low only for a passing comparator with good contact
  function automatic logic exp_pass_n(input logic p, input logic c);
    return !(p && c);
  endfunction
  // expected fail pin: the complement, so exactly one of the two is low
  function automatic logic exp_fail_n(input logic p, input logic c);
    return p && c;
  endfunction
  // verdict and end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= wd;
    @(posedge mclk);
    // no cycle count assumed; only the watchdog ends a hung wait
    while (wbAck !== 1'b1) begin
      @(posedge mclk);
    end
    rdat = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  // wait for end of conversion, tracking when the verdict last moved
  task automatic meas_wait(input int ad, input bit timed);
    int n, lastChg;
    logic [1:0] v;
    n = 0;
    lastChg = 0;
    v = {passN, failN};
    while (!(n > 8 && doneN === 1'b0) && n < ad + LEAD_CYC + 300) begin
      @(posedge mclk);
      n++;
      if ({passN, failN} !== v) lastChg = n;
      v = {passN, failN};
    end
    check("done_n", doneN, 1'b0);
    if (timed) check("cycle_time", 32'(n >= ad + LEAD_CYC && n <= ad + LEAD_CYC + 8), 32'h1);
    check("lead_time", 32'(n - lastChg >= LEAD_CYC || lastChg == 0), 32'h1);
    check("pass_n", passN, exp_pass_n(mp, cg));
    check("fail_n", failN, exp_fail_n(mp, cg));
    check("contact_n", contactFailN, cg);
  endtask
  // main sequence
  initial begin
    void'($urandom(93832));
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    check("volt_en", tvEn, 1'b0);
    wb(1'b0, ADR_CTRL, 32'h0, rd);
    check("ctrl_rst", rd, 32'h8);
    wb(1'b0, 4'hc, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    u_handler_model.charge_pulse();
    check("volt_en", tvEn, 1'b1);
    check("no_volt_n", noVoltN, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0, rd);
    check("state", rd[2:0], ST_CHARGE);
    repeat (CHG_C) @(posedge mclk);
    wb(1'b0, ADR_STATUS, 32'h0, rd);
    check("state", rd[2:0], ST_READY);
    // each rate, external trigger held high past the measurement
    for (i = 0; i < 3; i++) begin
      wb(1'b1, ADR_CTRL, 32'(i) | 32'h8, rd);
      mp <= 1'($urandom);
      // third rate forces a bad contact: fails whatever the comparator says
      cg <= (i == 2) ? 1'b0 : 1'($urandom);
      u_handler_model.trig_rise(i[0]);
      meas_wait(AD_C[i], 1'b1);
      repeat (NEXT_CYC + 20) @(posedge mclk);
      wb(1'b0, ADR_COUNT, 32'h0, rd);
      check("count", rd, 32'(i + 1));
      check("pass_hold", passN, exp_pass_n(mp, cg));
      u_handler_model.trig_fall();
    end
    // internal mode runs on its own
    mp <= 1'b1;
    cg <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h0, rd);
    repeat (4 * (AD_C[0] + 2 * LEAD_CYC)) @(posedge mclk);
    wb(1'b1, ADR_CTRL, 32'h4, rd);
    repeat (AD_C[0] + 2 * LEAD_CYC + 40) @(posedge mclk);
    wb(1'b0, ADR_COUNT, 32'h0, rd);
    check("count_int", 32'(rd >= 32'd5), 32'h1);
    cnt = int'(rd);
    // manual mode: pin edge ignored, software trigger taken
    u_handler_model.trig_rise(1'b0);
    repeat (AD_C[0] + 2 * LEAD_CYC + 40) @(posedge mclk);
    u_handler_model.trig_fall();
    wb(1'b0, ADR_COUNT, 32'h0, rd);
    check("count_man", rd, 32'(cnt));
    mp <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h44, rd);
    meas_wait(AD_C[0], 1'b0);
    wb(1'b0, ADR_COUNT, 32'h0, rd);
    check("count_sw", rd, 32'(cnt + 1));
    // discharge: sources off, results held, then released
    u_handler_model.discharge_pulse();
    check("volt_en", tvEn, 1'b0);
    check("pre_en", pcEn, 1'b0);
    check("no_volt_n", noVoltN, 1'b0);
    check("fail_hold", failN, 1'b0);
    repeat (DIS_C) @(posedge mclk);
    check("outs_rel", {passN, failN, contactFailN, doneN}, 4'hf);
    // software charge, then software discharge from the charging state
    wb(1'b1, ADR_CTRL, 32'h10, rd);
    @(posedge mclk);
    check("sw_chg", tvEn, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h20, rd);
    @(posedge mclk);
    check("sw_dis", {tvEn, pcEn, noVoltN}, 3'h0);
    report_and_stop();
  end
  // hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
endmodule
